// >>> hdl/rcc_divider.sv
/*
  Tick divider: one output tick per divisor input ticks.
  Assumes a divisor of zero or one means pass every tick through.
*/
`timescale 1ns/1ps
module rcc_divider
  import rcc_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  rcc_div_if.div dv
);
  logic [DIV_W-1:0] cnt_ff;
  logic tick_out_ff;
  logic last;

  assign last = (dv.divisor <= DIV_ONE) || (cnt_ff >= dv.divisor - DIV_ONE);

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      cnt_ff <= '0;
      tick_out_ff <= 1'b0;
    end
    else
    begin
      tick_out_ff <= dv.tick_in && last;
      if (dv.tick_in)
        cnt_ff <= last ? '0 : cnt_ff + DIV_ONE;
    end
  end

  assign dv.tick_out = tick_out_ff;

  AST_DIV_NO_EARLY: assert property (@(posedge clk) disable iff (!nrst)
    (dv.tick_in && !last) |=> !dv.tick_out)
    else $error("Divider ticked before its count ran out");
endmodule

// >>> hdl/rcc_reset_clock.sv
/*
  Reset level sequencing, reset cause capture and clock tick generation.
  Assumes request inputs come from logic on clk; source clock pins are
  asynchronous and are synchronised here. Clocks leave as tick pulses.
*/
// Summary of operation
// - Per-core reset; release restarts at vector
// - Core level resets digital side, spares always-on
// - System level adds always-on; chip resets all
// - Only chip level clears internal memory
// - Core 0 reset also clears sensitive registers
// - Any level resets both cores at once
// - Per-core cause; shared global, private per-core
// - Power-on 0x01, brown-out 0x0F
// - System causes 0x10, 0x12, 0x13
// - Core causes 0x03,0x05,0x07,0x08,0x09
// - Fuse CRC error: core reset, 0x14
// - USB serial 0x15, JTAG 0x16 core resets
// - Per-core causes 0x0B,0x0C,0x0D,0x11
// - Source select: crystal, PLL, fast RC
// - After reset: crystal divided by two
// - Crystal or RC divided by predivider plus one
// - 480 MHz PLL divided by 6, 3, 2
// - 320 MHz PLL divided by 4, 2
// - Bus clock 80 MHz on PLL, else CPU
// - Cipher clock 160 MHz on PLL, else CPU
// - LED clock from fast RC when bus off
// - Radios only on PLL; sleep before suspend
// - Divided fast RC is fast RC over 256
// - Slow and fast always-on clock selection
`timescale 1ns/1ps
module rcc_reset_clock
  import rcc_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic power_on_req,
  input wire logic brownout_req,
  input wire logic brownout_chip_cfg,
  input wire logic aon_wdt_sys_req,
  input wire logic super_wdt_req,
  input wire logic glitch_req,
  input wire logic software_system_reset_bit,
  input wire logic deep_sleep_wake_req,
  input wire logic main_wdt0_core_req,
  input wire logic main_wdt1_core_req,
  input wire logic aon_wdt_core_req,
  input wire logic fuse_crc_error,
  input wire logic usb_serial_reset_req,
  input wire logic usb_jtag_reset_req,
  input wire logic [NUM_CORES-1:0] main_wdt0_cpu_req,
  input wire logic [NUM_CORES-1:0] software_core_reset_bit,
  input wire logic [NUM_CORES-1:0] aon_wdt_cpu_req,
  input wire logic [NUM_CORES-1:0] main_wdt1_cpu_req,
  input wire logic crystal_clock,
  input wire logic pll_clock,
  input wire logic fast_rc_clock,
  input wire logic low_rc_clock,
  input wire logic watch_crystal_clock,
  input wire logic clock_config_write,
  input wire logic [1:0] cpu_source_select,
  input wire logic [PRE_DIV_W-1:0] cpu_clock_predivider,
  input wire logic synth_frequency_select,
  input wire logic [1:0] cpu_period_select,
  input wire logic bus_clock_off,
  input wire logic [1:0] slow_aon_select,
  input wire logic fast_aon_from_rc,
  input wire logic radio_low_power,
  output logic [NUM_CORES-1:0] cpu_reset,
  output logic [NUM_CORES-1:0] cpu_fetch_vector,
  output logic digital_reset,
  output logic aon_reset,
  output logic chip_reset,
  output logic memory_reset,
  output logic sensitive_reset,
  output rcc_cause_type core0_reset_cause,
  output rcc_cause_type core1_reset_cause,
  output logic cpu_clock_tick,
  output logic bus_clock_tick,
  output logic cipher_pulse_tick,
  output logic led_controller_tick,
  output logic divided_fast_rc_tick,
  output logic slow_aon_tick,
  output logic fast_aon_tick,
  output logic radio_enable,
  output logic pll_suspend_ok
);

  ////////////////////////////////////////////////////////////////////////////
  // Global reset levels

  logic chip_req, sys_req, core_req, glob_req;
  rcc_level_type req_lvl, lvl_ff, nxt_lvl;
  rcc_cause_type glob_cause;
  logic [HOLD_W-1:0] hold_ff;

  always_comb
  begin
    chip_req = power_on_req || (brownout_req && brownout_chip_cfg);
    sys_req = (brownout_req && !brownout_chip_cfg) || aon_wdt_sys_req
      || super_wdt_req || glitch_req;
    core_req = software_system_reset_bit || deep_sleep_wake_req
      || main_wdt0_core_req || main_wdt1_core_req || aon_wdt_core_req
      || fuse_crc_error || usb_serial_reset_req || usb_jtag_reset_req;
    glob_req = chip_req || sys_req || core_req;
    if (chip_req)
      req_lvl = LVL_CHIP;
    else if (sys_req)
      req_lvl = LVL_SYS;
    else if (core_req)
      req_lvl = LVL_CORE;
    else
      req_lvl = LVL_NONE;
  end

  // Highest level request names the cause when several arrive together
  always_comb
  begin
    if (power_on_req)
      glob_cause = CAUSE_POWER_ON;
    else if (brownout_req)
      glob_cause = CAUSE_BROWNOUT;
    else if (aon_wdt_sys_req)
      glob_cause = CAUSE_AON_WDT_SYS;
    else if (super_wdt_req)
      glob_cause = CAUSE_SUPER_WDT;
    else if (glitch_req)
      glob_cause = CAUSE_GLITCH;
    else if (software_system_reset_bit)
      glob_cause = CAUSE_SW_SYS;
    else if (deep_sleep_wake_req)
      glob_cause = CAUSE_DEEP_SLEEP;
    else if (main_wdt0_core_req)
      glob_cause = CAUSE_MAIN_WATCHDOG_ZERO_CORE;
    else if (main_wdt1_core_req)
      glob_cause = CAUSE_MAIN_WATCHDOG_ONE_CORE;
    else if (aon_wdt_core_req)
      glob_cause = CAUSE_AON_WDT_CORE;
    else if (fuse_crc_error)
      glob_cause = CAUSE_FUSE_CRC;
    else if (usb_serial_reset_req)
      glob_cause = CAUSE_USB_SERIAL;
    else if (usb_jtag_reset_req)
      glob_cause = CAUSE_USB_JTAG;
    else
      glob_cause = CAUSE_NONE;
  end

  // A new request restarts the hold; a lower one never demotes a higher level
  always_comb
  begin
    nxt_lvl = lvl_ff;
    if (glob_req)
      nxt_lvl = (lvl_ff > req_lvl) ? lvl_ff : req_lvl;
    else if (lvl_ff != LVL_NONE && hold_ff == HOLD_ZERO)
      nxt_lvl = LVL_NONE;
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      lvl_ff <= LVL_CHIP;
      hold_ff <= HOLD_INIT;
    end
    else
    begin
      lvl_ff <= nxt_lvl;
      if (glob_req)
        hold_ff <= HOLD_INIT;
      else if (hold_ff != HOLD_ZERO)
        hold_ff <= hold_ff - HOLD_ONE;
    end
  end

  logic digital_reset_ff, aon_reset_ff, chip_reset_ff, memory_reset_ff;

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      digital_reset_ff <= 1'b1;
      aon_reset_ff <= 1'b1;
      chip_reset_ff <= 1'b1;
      memory_reset_ff <= 1'b1;
    end
    else
    begin
      memory_reset_ff <= (nxt_lvl == LVL_CHIP);
      case (nxt_lvl)
        LVL_CHIP:
        begin
          digital_reset_ff <= 1'b1;
          aon_reset_ff <= 1'b1;
          chip_reset_ff <= 1'b1;
        end
        LVL_SYS:
        begin
          digital_reset_ff <= 1'b1;
          aon_reset_ff <= 1'b1;
          chip_reset_ff <= 1'b0;
        end
        LVL_CORE:
        begin
          digital_reset_ff <= 1'b1;
          aon_reset_ff <= 1'b0;
          chip_reset_ff <= 1'b0;
        end
        default:
        begin
          digital_reset_ff <= 1'b0;
          aon_reset_ff <= 1'b0;
          chip_reset_ff <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-core resets and causes

  logic [NUM_CORES-1:0] cpu_req, nxt_cpu_act, cpu_act_ff, cpu_reset_ff, fetch_ff;
  rcc_cause_type cause_ff [NUM_CORES];
  logic sensitive_reset_ff;

  for (genvar i = 0; i < NUM_CORES; i++)
  begin : g_core
    rcc_cause_type own_cause;
    logic [HOLD_W-1:0] cpu_hold_ff;

    assign cpu_req[i] = main_wdt0_cpu_req[i] || software_core_reset_bit[i]
      || aon_wdt_cpu_req[i] || main_wdt1_cpu_req[i];
    assign own_cause = main_wdt0_cpu_req[i] ? CAUSE_MAIN_WATCHDOG_ZERO_CPU :
      software_core_reset_bit[i] ? CAUSE_SW_CPU :
      aon_wdt_cpu_req[i] ? CAUSE_AON_WDT_CPU : CAUSE_MAIN_WATCHDOG_ONE_CPU;
    assign nxt_cpu_act[i] = cpu_req[i] || (cpu_act_ff[i] && cpu_hold_ff != HOLD_ZERO);

    always_ff @(posedge clk)
    begin
      if (!nrst)
      begin
        cpu_act_ff[i] <= 1'b0;
        cpu_hold_ff <= HOLD_ZERO;
      end
      else
      begin
        cpu_act_ff[i] <= nxt_cpu_act[i];
        if (cpu_req[i])
          cpu_hold_ff <= HOLD_INIT;
        else if (cpu_hold_ff != HOLD_ZERO)
          cpu_hold_ff <= cpu_hold_ff - HOLD_ONE;
      end
    end

    // Core held by its own reset or by any level; release pulses the fetch
    always_ff @(posedge clk)
    begin
      if (!nrst)
      begin
        cpu_reset_ff[i] <= 1'b1;
        fetch_ff[i] <= 1'b0;
      end
      else
      begin
        cpu_reset_ff[i] <= nxt_cpu_act[i] || (nxt_lvl != LVL_NONE);
        fetch_ff[i] <= cpu_reset_ff[i] && !(nxt_cpu_act[i] || nxt_lvl != LVL_NONE);
      end
    end

    // Shared causes reach both cores, private ones only this core
    always_ff @(posedge clk)
    begin
      if (!nrst)
        cause_ff[i] <= CAUSE_POWER_ON;
      else if (glob_req)
        cause_ff[i] <= glob_cause;
      else if (cpu_req[i])
        cause_ff[i] <= own_cause;
    end

    AST_VECTOR_ON_RELEASE: assert property (@(posedge clk) disable iff (!nrst)
      $fell(cpu_reset_ff[i]) |-> fetch_ff[i])
      else $error("Core released without a vector fetch pulse");
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
      sensitive_reset_ff <= 1'b1;
    else
      sensitive_reset_ff <= nxt_cpu_act[0] || (nxt_lvl != LVL_NONE);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Source synchronisers and clock configuration

  logic [NUM_PINS-1:0] pins, sync1_ff, sync2_ff, sync3_ff, src_tick;

  assign pins = {watch_crystal_clock, low_rc_clock, fast_rc_clock, pll_clock, crystal_clock};

  // Sources must run below half of clk; rising edges come out one tick each
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      sync1_ff <= '0;
      sync2_ff <= '0;
      sync3_ff <= '0;
    end
    else
    begin
      sync1_ff <= pins;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
    end
  end

  assign src_tick = sync2_ff & ~sync3_ff;

  logic [1:0] cfg_src_ff, cfg_period_ff;
  logic [PRE_DIV_W-1:0] cfg_prediv_ff;
  logic cfg_synth_ff;

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      cfg_src_ff <= SRC_XTAL;
      cfg_prediv_ff <= PRE_DIV_RST;
      cfg_synth_ff <= SYNTH_320;
      cfg_period_ff <= PERIOD_0;
    end
    else if (clock_config_write)
    begin
      cfg_src_ff <= cpu_source_select;
      cfg_prediv_ff <= cpu_clock_predivider;
      cfg_synth_ff <= synth_frequency_select;
      cfg_period_ff <= cpu_period_select;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Dividers

  rcc_div_if dv_if [NUM_DIV] ();

  for (genvar g = 0; g < NUM_DIV; g++)
  begin : g_div
    rcc_divider u_div (.clk(clk), .nrst(nrst), .dv(dv_if[g]));
  end

  logic [DIV_W-1:0] pll_cpu_div;

  // Unlisted period codes fall back to the fastest listed ratio
  always_comb
  begin
    if (cfg_synth_ff == SYNTH_480)
      pll_cpu_div = (cfg_period_ff == PERIOD_0) ? DIV_PLL480_P0 :
        (cfg_period_ff == PERIOD_1) ? DIV_PLL480_P1 : DIV_PLL480_P2;
    else
      pll_cpu_div = (cfg_period_ff == PERIOD_0) ? DIV_PLL320_P0 : DIV_PLL320_P1;
  end

  // Unused source code 3 behaves as crystal
  assign dv_if[DV_CPU].tick_in = (cfg_src_ff == SRC_PLL) ? src_tick[PIN_PLL] :
    (cfg_src_ff == SRC_FRC) ? src_tick[PIN_FRC] : src_tick[PIN_XTAL];
  assign dv_if[DV_CPU].divisor = (cfg_src_ff == SRC_PLL) ? pll_cpu_div :
    {1'b0, cfg_prediv_ff} + DIV_ONE;
  assign dv_if[DV_BUS].tick_in = src_tick[PIN_PLL];
  assign dv_if[DV_BUS].divisor = (cfg_synth_ff == SYNTH_480) ? DIV_PLL480_P0 : DIV_PLL320_P0;
  assign dv_if[DV_CIPH].tick_in = src_tick[PIN_PLL];
  assign dv_if[DV_CIPH].divisor = (cfg_synth_ff == SYNTH_480) ? DIV_PLL480_P1 : DIV_PLL320_P1;
  assign dv_if[DV_FRC].tick_in = src_tick[PIN_FRC];
  assign dv_if[DV_FRC].divisor = DIV_FRC_SLOW;
  assign dv_if[DV_FAON].tick_in = src_tick[PIN_XTAL];
  assign dv_if[DV_FAON].divisor = DIV_FAST_AON_XTAL;

  ////////////////////////////////////////////////////////////////////////////
  // Derived clock ticks

  logic on_pll, nxt_bus_tick;
  logic cpu_tick_ff, bus_tick_ff, ciph_tick_ff, led_tick_ff;
  logic frc_div_tick_ff, slow_tick_ff, fast_tick_ff, radio_en_ff, pll_ok_ff;

  assign on_pll = (cfg_src_ff == SRC_PLL);
  assign nxt_bus_tick = on_pll ? dv_if[DV_BUS].tick_out : dv_if[DV_CPU].tick_out;

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      cpu_tick_ff <= 1'b0;
      bus_tick_ff <= 1'b0;
      ciph_tick_ff <= 1'b0;
      led_tick_ff <= 1'b0;
    end
    else
    begin
      cpu_tick_ff <= dv_if[DV_CPU].tick_out;
      bus_tick_ff <= nxt_bus_tick && !bus_clock_off;
      ciph_tick_ff <= on_pll ? dv_if[DV_CIPH].tick_out : dv_if[DV_CPU].tick_out;
      led_tick_ff <= bus_clock_off ? src_tick[PIN_FRC] : nxt_bus_tick;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      frc_div_tick_ff <= 1'b0;
      slow_tick_ff <= 1'b0;
      fast_tick_ff <= 1'b0;
    end
    else
    begin
      frc_div_tick_ff <= dv_if[DV_FRC].tick_out;
      case (slow_aon_select)
        SLOW_WATCH: slow_tick_ff <= src_tick[PIN_WATCH];
        SLOW_FRC_DIV: slow_tick_ff <= dv_if[DV_FRC].tick_out;
        default: slow_tick_ff <= src_tick[PIN_LRC];
      endcase
      fast_tick_ff <= fast_aon_from_rc ? src_tick[PIN_FRC] : dv_if[DV_FAON].tick_out;
    end
  end

  // Radios run only on the PLL; suspend is safe once they sleep
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      radio_en_ff <= 1'b0;
      pll_ok_ff <= 1'b0;
    end
    else
    begin
      radio_en_ff <= on_pll;
      pll_ok_ff <= radio_low_power;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign cpu_reset = cpu_reset_ff;
  assign cpu_fetch_vector = fetch_ff;
  assign digital_reset = digital_reset_ff;
  assign aon_reset = aon_reset_ff;
  assign chip_reset = chip_reset_ff;
  assign memory_reset = memory_reset_ff;
  assign sensitive_reset = sensitive_reset_ff;
  assign core0_reset_cause = cause_ff[0];
  assign core1_reset_cause = cause_ff[1];
  assign cpu_clock_tick = cpu_tick_ff;
  assign bus_clock_tick = bus_tick_ff;
  assign cipher_pulse_tick = ciph_tick_ff;
  assign led_controller_tick = led_tick_ff;
  assign divided_fast_rc_tick = frc_div_tick_ff;
  assign slow_aon_tick = slow_tick_ff;
  assign fast_aon_tick = fast_tick_ff;
  assign radio_enable = radio_en_ff;
  assign pll_suspend_ok = pll_ok_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  AST_BOTH_CORES_ON_LEVEL: assert property (@(posedge clk) disable iff (!nrst)
    glob_req |=> (&cpu_reset_ff) && digital_reset_ff)
    else $error("A reset level left a core running");

  AST_CORE_SPARES_AON: assert property (@(posedge clk) disable iff (!nrst)
    (core_req && !chip_req && !sys_req && lvl_ff == LVL_NONE) |=> !aon_reset_ff)
    else $error("Core level reset hit the always-on domain");

  AST_SYS_HITS_AON: assert property (@(posedge clk) disable iff (!nrst)
    sys_req |=> aon_reset_ff ##1 aon_reset_ff)
    else $error("System level reset missed the always-on domain");

  AST_MEMORY_ONLY_CHIP: assert property (@(posedge clk) disable iff (!nrst)
    memory_reset_ff |-> chip_reset_ff)
    else $error("Memory cleared without a chip level reset");

  AST_SENSITIVE_WITH_CORE0: assert property (@(posedge clk) disable iff (!nrst)
    cpu_req[0] |=> sensitive_reset_ff)
    else $error("Core 0 reset did not clear sensitive registers");

  AST_POWER_ON_CODE: assert property (@(posedge clk) disable iff (!nrst)
    power_on_req |=> core0_reset_cause == 5'h01 && core1_reset_cause == 5'h01)
    else $error("Power-on cause code not recorded on both cores");

  AST_PRIVATE_CAUSE: assert property (@(posedge clk) disable iff (!nrst)
    (cpu_req[1] && !glob_req && !cpu_req[0]) |=> $stable(core0_reset_cause))
    else $error("Core 1 private reset changed core 0 cause");

  AST_SW_CORE_CODE: assert property (@(posedge clk) disable iff (!nrst)
    (software_core_reset_bit[1] && !main_wdt0_cpu_req[1] && !glob_req)
      |=> core1_reset_cause == 5'h0C)
    else $error("Software core reset code not recorded");

  AST_RELEASE_AFTER_HOLD: assert property (@(posedge clk) disable iff (!nrst)
    (glob_req ##1 (!glob_req && !(|cpu_req)) [*8]) |-> digital_reset_ff)
    else $error("Reset released before its hold time");

  AST_RADIO_NEEDS_PLL: assert property (@(posedge clk) disable iff (!nrst)
    (cfg_src_ff != SRC_PLL) |=> !radio_enable)
    else $error("Radios enabled off the PLL");
endmodule

// >>> pkg/rcc_div_if.sv
/*
  Carrier between the control block and one tick divider.
  Assumes both ends run on the same system clock.
*/
`timescale 1ns/1ps
interface rcc_div_if;
  import rcc_pkg::*;
  logic tick_in;
  logic [DIV_W-1:0] divisor;
  logic tick_out;
  modport ctrl (output tick_in, output divisor, input tick_out);
  modport div (input tick_in, input divisor, output tick_out);
endinterface

// >>> pkg/rcc_pkg.sv
/*
  Shared constants for the reset and clock control block: cause codes,
  clock select encodings, divider ratios, reset hold time, level states.
  Assumes a single 250 MHz system clock and a synchronous active-low reset.
*/
package rcc_pkg;
  localparam int CLK_PERIOD_PS = 4000;
  localparam int RST_HOLD_NS = 40;
  localparam int RST_HOLD_CYC = (RST_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int HOLD_W = 4;
  localparam logic [HOLD_W-1:0] HOLD_INIT = HOLD_W'(RST_HOLD_CYC - 1);
  localparam logic [HOLD_W-1:0] HOLD_ZERO = 4'h0;
  localparam logic [HOLD_W-1:0] HOLD_ONE = 4'h1;
  localparam int NUM_CORES = 2;

  localparam int CAUSE_W = 5;
  typedef logic [CAUSE_W-1:0] rcc_cause_type;
  localparam rcc_cause_type CAUSE_NONE = 5'h00;
  localparam rcc_cause_type CAUSE_POWER_ON = 5'h01;
  localparam rcc_cause_type CAUSE_BROWNOUT = 5'h0F;
  localparam rcc_cause_type CAUSE_AON_WDT_SYS = 5'h10;
  localparam rcc_cause_type CAUSE_SUPER_WDT = 5'h12;
  localparam rcc_cause_type CAUSE_GLITCH = 5'h13;
  localparam rcc_cause_type CAUSE_SW_SYS = 5'h03;
  localparam rcc_cause_type CAUSE_DEEP_SLEEP = 5'h05;
  localparam rcc_cause_type CAUSE_MAIN_WATCHDOG_ZERO_CORE = 5'h07;
  localparam rcc_cause_type CAUSE_MAIN_WATCHDOG_ONE_CORE = 5'h08;
  localparam rcc_cause_type CAUSE_AON_WDT_CORE = 5'h09;
  localparam rcc_cause_type CAUSE_FUSE_CRC = 5'h14;
  localparam rcc_cause_type CAUSE_USB_SERIAL = 5'h15;
  localparam rcc_cause_type CAUSE_USB_JTAG = 5'h16;
  localparam rcc_cause_type CAUSE_MAIN_WATCHDOG_ZERO_CPU = 5'h0B;
  localparam rcc_cause_type CAUSE_SW_CPU = 5'h0C;
  localparam rcc_cause_type CAUSE_AON_WDT_CPU = 5'h0D;
  localparam rcc_cause_type CAUSE_MAIN_WATCHDOG_ONE_CPU = 5'h11;

  typedef enum logic [3:0] {
    LVL_NONE = 4'h1,
    LVL_CORE = 4'h2,
    LVL_SYS = 4'h4,
    LVL_CHIP = 4'h8
  } rcc_level_type;

  localparam logic [1:0] SRC_XTAL = 2'h0;
  localparam logic [1:0] SRC_PLL = 2'h1;
  localparam logic [1:0] SRC_FRC = 2'h2;
  localparam logic SYNTH_320 = 1'h0;
  localparam logic SYNTH_480 = 1'h1;
  localparam logic [1:0] PERIOD_0 = 2'h0;
  localparam logic [1:0] PERIOD_1 = 2'h1;
  localparam logic [1:0] SLOW_LOW_RC = 2'h0;
  localparam logic [1:0] SLOW_WATCH = 2'h1;
  localparam logic [1:0] SLOW_FRC_DIV = 2'h2;

  localparam int PRE_DIV_W = 10;
  localparam logic [PRE_DIV_W-1:0] PRE_DIV_RST = 10'h001;
  localparam int DIV_W = 11;
  localparam logic [DIV_W-1:0] DIV_ONE = 11'h001;
  localparam logic [DIV_W-1:0] DIV_PLL480_P0 = 11'h006;
  localparam logic [DIV_W-1:0] DIV_PLL480_P1 = 11'h003;
  localparam logic [DIV_W-1:0] DIV_PLL480_P2 = 11'h002;
  localparam logic [DIV_W-1:0] DIV_PLL320_P0 = 11'h004;
  localparam logic [DIV_W-1:0] DIV_PLL320_P1 = 11'h002;
  localparam logic [DIV_W-1:0] DIV_FRC_SLOW = 11'h100;
  localparam logic [DIV_W-1:0] DIV_FAST_AON_XTAL = 11'h004;

  localparam int PIN_XTAL = 0;
  localparam int PIN_PLL = 1;
  localparam int PIN_FRC = 2;
  localparam int PIN_LRC = 3;
  localparam int PIN_WATCH = 4;
  localparam int NUM_PINS = 5;
  localparam int DV_CPU = 0;
  localparam int DV_BUS = 1;
  localparam int DV_CIPH = 2;
  localparam int DV_FRC = 3;
  localparam int DV_FAON = 4;
  localparam int NUM_DIV = 5;
endpackage

// >>> verif/rcc_periph_model.sv
/*
  Peripheral side model: counts the clock ticks it is fed.
  Assumes ticks are one-cycle pulses on clk.
*/
`timescale 1ns/1ps
module rcc_periph_model (
  input wire logic clk,
  input wire logic clr,
  input wire logic cpu_tick,
  input wire logic bus_tick,
  input wire logic led_tick,
  input wire logic cip_tick,
  input wire logic slo_tick,
  input wire logic fst_tick,
  output int cpu_cnt,
  output int bus_cnt,
  output int led_cnt,
  output int cip_cnt,
  output int slo_cnt,
  output int fst_cnt
);
  // Counts only, no reaction: peripherals never push back
  always_ff @(posedge clk)
  begin
    cpu_cnt <= clr ? 0 : cpu_cnt + int'(cpu_tick);
    bus_cnt <= clr ? 0 : bus_cnt + int'(bus_tick);
    led_cnt <= clr ? 0 : led_cnt + int'(led_tick);
    cip_cnt <= clr ? 0 : cip_cnt + int'(cip_tick);
    slo_cnt <= clr ? 0 : slo_cnt + int'(slo_tick);
    fst_cnt <= clr ? 0 : fst_cnt + int'(fst_tick);
  end
endmodule

// >>> verif/testbench.sv
/*
  Bench: reset levels, cause codes and clock ratios at the ports.
  Assumes source clocks built from a cycle count, slower than clk/2.
*/
`timescale 1ns/1ps
module testbench
  import rcc_pkg::*;
;
  logic clk = 0;
  logic nrst = 0;
  logic clr = 1;
  logic [12:0] g = '0;
  logic [1:0] p [4] = '{default: '0};
  logic cfg_w = 0;
  logic [1:0] src = 0;
  logic [9:0] div = 0;
  logic syn = 0;
  logic [1:0] per = 0;
  logic bus_off = 0;
  logic bo_chip = 0;
  logic [7:0] cyc = 0;
  logic [1:0] cpu_reset, cpu_fetch_vector;
  logic digital_reset, aon_reset, chip_reset, memory_reset, sensitive_reset;
  rcc_cause_type core0_reset_cause, core1_reset_cause;
  logic cpu_clock_tick, bus_clock_tick, led_controller_tick, radio_enable;
  logic cipher_pulse_tick, slow_aon_tick, fast_aon_tick, pll_suspend_ok;
  rcc_cause_type ec [2];
  rcc_cause_type gc [13] = '{5'h01, 5'h0F, 5'h10, 5'h12, 5'h13, 5'h03, 5'h05, 5'h07,
    5'h08, 5'h09, 5'h14, 5'h15, 5'h16};
  rcc_cause_type pc [4] = '{5'h0B, 5'h0C, 5'h0D, 5'h11};
  int failures = 0;
  int checked = 0;
  int cpu_cnt, bus_cnt, led_cnt, cip_cnt, slo_cnt, fst_cnt;
  rcc_reset_clock uut (.clk, .nrst, .power_on_req(g[0]), .brownout_req(g[1]),
    .brownout_chip_cfg(bo_chip), .aon_wdt_sys_req(g[2]), .super_wdt_req(g[3]), .glitch_req(g[4]),
    .software_system_reset_bit(g[5]), .deep_sleep_wake_req(g[6]), .main_wdt0_core_req(g[7]),
    .main_wdt1_core_req(g[8]), .aon_wdt_core_req(g[9]), .fuse_crc_error(g[10]),
    .usb_serial_reset_req(g[11]), .usb_jtag_reset_req(g[12]), .main_wdt0_cpu_req(p[0]),
    .software_core_reset_bit(p[1]), .aon_wdt_cpu_req(p[2]), .main_wdt1_cpu_req(p[3]),
    .crystal_clock(cyc[1]), .pll_clock(cyc[1]), .fast_rc_clock(cyc[2]),
    .low_rc_clock(cyc[3]), .watch_crystal_clock(cyc[4]), .clock_config_write(cfg_w),
    .cpu_source_select(src), .cpu_clock_predivider(div), .synth_frequency_select(syn),
    .cpu_period_select(per), .bus_clock_off(bus_off), .slow_aon_select(2'h0),
    .fast_aon_from_rc(bus_off), .radio_low_power(bus_off), .cpu_reset, .cpu_fetch_vector,
    .digital_reset, .aon_reset, .chip_reset, .memory_reset, .sensitive_reset,
    .core0_reset_cause, .core1_reset_cause, .cpu_clock_tick, .bus_clock_tick,
    .cipher_pulse_tick, .led_controller_tick, .divided_fast_rc_tick(), .slow_aon_tick,
    .fast_aon_tick, .radio_enable, .pll_suspend_ok);
  rcc_periph_model peers (.clk, .clr, .cpu_tick(cpu_clock_tick), .bus_tick(bus_clock_tick),
    .led_tick(led_controller_tick), .cip_tick(cipher_pulse_tick), .slo_tick(slow_aon_tick),
    .fst_tick(fast_aon_tick), .cpu_cnt, .bus_cnt, .led_cnt, .cip_cnt, .slo_cnt, .fst_cnt);
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    forever #2 clk = ~clk;
  end
  // One source pair shares a bit, so ratios are exact
  always @(posedge clk)
  begin
    cyc <= cyc + 8'h01;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // Window edges cut a tick either way, hence one of slack
  task automatic near(input int got, input int exp);
    checked++;
    if (got < exp - 1 || got > exp + 1)
    begin
      failures++;
      $display("mismatch at %0t: count %0d exp %0d", $time, got, exp);
    end
  endtask
  task automatic conclude;
    if (failures == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic fire(input logic [1:0] m);
    @(posedge clk);
    g <= '0;
    p <= '{default: '0};
    @(posedge clk);
    #1;
    cmp(cpu_reset, m);
    cmp({core0_reset_cause, core1_reset_cause}, {ec[0], ec[1]});
  endtask
  task automatic drop_wait(input logic [1:0] m);
    repeat (8) @(posedge clk);
    #1;
    cmp(cpu_reset, m);
    @(posedge clk);
    #1;
    cmp({cpu_reset, cpu_fetch_vector}, {2'h0, m});
    cmp({core0_reset_cause, core1_reset_cause}, {ec[0], ec[1]});
  endtask
  task automatic t_global;
    for (int i = 0; i < 13; i++)
    begin
      @(posedge clk);
      g[i] <= 1'b1;
      ec = '{gc[i], gc[i]};
      fire(2'h3);
      cmp({digital_reset, aon_reset, chip_reset, memory_reset},
        {1'b1, i < 5, i < 1, i < 1});
      drop_wait(2'h3);
    end
    @(posedge clk);
    bo_chip <= 1'b1;
    g[1] <= 1'b1;
    ec = '{gc[1], gc[1]};
    fire(2'h3);
    cmp({chip_reset, memory_reset}, 2'h3);
    drop_wait(2'h3);
  endtask
  task automatic t_core;
    for (int c = 0; c < 2; c++)
      for (int k = 0; k < 4; k++)
      begin
        @(posedge clk);
        p[k][c] <= 1'b1;
        ec[c] = pc[k];
        fire(2'(1 << c));
        cmp({digital_reset, sensitive_reset}, {1'b0, c == 0});
        drop_wait(2'(1 << c));
      end
  endtask
  task automatic clk_case(input logic w, input logic [1:0] s, input logic [9:0] d,
    input logic f, input logic [1:0] ps, input logic bo, input int e_cpu, input int e_bus);
    @(posedge clk);
    cfg_w <= w;
    src <= s;
    div <= d;
    syn <= f;
    per <= ps;
    bus_off <= bo;
    @(posedge clk);
    cfg_w <= 1'b0;
    clr <= 1'b1;
    repeat (40) @(posedge clk);
    clr <= 1'b0;
    repeat (960) @(posedge clk);
    #1;
    near(cpu_cnt, e_cpu);
    near(bus_cnt, e_bus);
    if (bo)
      near(led_cnt, 120);
    near(cip_cnt, (s == 2'h1) ? (f ? 80 : 120) : e_cpu);
    near(slo_cnt, 60);
    near(fst_cnt, bo ? 120 : 60);
    cmp({radio_enable, pll_suspend_ok}, {s == 2'h1, bo});
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    clk_case(0, 0, 0, 0, 0, 0, 120, 120);
    clk_case(1, 0, 3, 0, 0, 0, 60, 60);
    clk_case(1, 2, 0, 0, 0, 0, 120, 120);
    clk_case(1, 2, 1023, 0, 0, 1, 0, 0);
    clk_case(1, 1, 0, 1, 0, 0, 40, 40);
    clk_case(1, 1, 0, 1, 1, 0, 80, 40);
    clk_case(1, 1, 0, 1, 2, 0, 120, 40);
    clk_case(1, 1, 0, 0, 0, 0, 60, 60);
    clk_case(1, 1, 0, 0, 1, 0, 120, 60);
    t_global();
    t_core();
    conclude();
  end
  initial
  begin
    #100000;
    failures++;
    conclude();
  end
endmodule
